// ### src/sfpf_pkg.sv
// Purpose: Constants shared by the programmable-flag FIFO and its pin sampler.
// Assumes: One system clock; every device pin is sampled into that clock.
// Notes:   Pin vector indices describe how the top packs its raw pins.
// Function
// - After reset outputs read low when enabled, released when disabled.
// - Second enable pin sampled at reset selects dual-enable or load mode.
// - Read and write clocks may keep running during reset.
// - Dual-enable mode writes while first enable low and second high.
// - Load mode writes while first enable low and load high, independent of reads.
// - Both read enables low advance read pointer and present next word.
// - Output enable high releases outputs; low drives the output register.
// - Writes ignored when full, reads ignored when empty.
// - Empty FIFO keeps last valid word on the outputs.
// - Load writes fill offset registers in cyclic four-register order.
// - Four 8-bit offset registers, reached only through the load pin.
// - Sequence position survives raising load; next access continues.
// - Load low with reads enabled reads offsets in same cyclic order.
// - Almost-empty low at or below empty offset, high above, on read clock.
// - Almost-full low at depth minus full offset, high when room exceeds it.
// - Default empty and full offsets are seven.
// - Dual-ported array of 9-bit words, independent read and write pointers.
// - First word appears one read cycle after empty flag rises.
// - Full and empty deassertion may slip one edge on close clock edges.
// - Partial flags may change only on the following own-clock edge.
// - Full flag low when full, updated only by write clock, blocks writes.
// - Empty flag low when empty, updated only by read clock, blocks reads.
package sfpf_pkg;

  localparam int DATA_WIDTH  = 9;
  localparam int OFFSET_WIDTH = 8;
  localparam int DEPTH_DEFAULT = 64;

  localparam logic [7:0] EMPTY_OFFSET_LOW_RESET  = 8'h07;
  localparam logic [7:0] EMPTY_OFFSET_HIGH_RESET = 8'h00;
  localparam logic [7:0] FULL_OFFSET_LOW_RESET   = 8'h07;
  localparam logic [7:0] FULL_OFFSET_HIGH_RESET  = 8'h00;

  typedef enum logic [1:0] {
    SEL_EMPTY_LOW  = 2'h0,
    SEL_EMPTY_HIGH = 2'h1,
    SEL_FULL_LOW   = 2'h2,
    SEL_FULL_HIGH  = 2'h3
  } sfpf_sel_type;

  localparam int PIN_COUNT     = 17;
  localparam int PIN_DATA_LSB  = 0;
  localparam int PIN_OE_N      = 9;
  localparam int PIN_SECOND_READ_ENABLE_N_N    = 10;
  localparam int PIN_FIRST_READ_ENABLE_N_N    = 11;
  localparam int PIN_SECOND_WRITE_ENABLE_OR_LOAD   = 12;
  localparam int PIN_FIRST_WRITE_ENABLE_N_N    = 13;
  localparam int PIN_RESET_N   = 14;
  localparam int PIN_RCLK      = 15;
  localparam int PIN_WCLK      = 16;

endpackage

// ### src/sfpf_sync_if.sv
// Purpose: Carries raw pins into the sampler and sampled pins back out.
// Assumes: Width set by the user of the interface.
// Notes:   None.
`timescale 1ns/1ps
interface sfpf_sync_if #(parameter int WIDTH = 1);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport sampler (input raw, output synced);
  modport user (output raw, input synced);
endinterface

// ### src/sfpf_sync.sv
// Purpose: Two-flop sampler for a vector of asynchronous pins.
// Assumes: Bits are independent levels; no bus coherence is needed.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module sfpf_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pins
  sfpf_sync_if.sampler port
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sfpf_sync_state_type;

  sfpf_sync_state_type cur;
  sfpf_sync_state_type next_state;

  always_comb begin
    next_state        = cur;
    next_state.stage1 = port.raw;
    next_state.stage2 = cur.stage1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // Flush to the idle high level, so that no active-low pin looks
      // asserted and no pin reset is seen while the stages refill.
      cur <= '1;
    end else begin
      cur <= next_state;
    end
  end

  assign port.synced = cur.stage2;

endmodule // sfpf_sync

// ### src/sfpf_fifo.sv
// Purpose: FIFO of 9-bit words with empty, full and programmable flags.
// Assumes: Device clocks arrive as pins and are edge-detected on clk.
// Notes:   Both device clocks must be well below half the clk rate.
`timescale 1ns/1ps
module sfpf_fifo
  import sfpf_pkg::*;
#(
  parameter int DEPTH = sfpf_pkg::DEPTH_DEFAULT
) (
  // System clock and reset
  input  wire logic                            clk,
  input  wire logic                            rstn,
  // Write port pins
  input  wire logic                            write_clock,
  input  wire logic                            first_write_enable_n,
  input  wire logic                            second_write_enable_or_load,
  input  wire logic [sfpf_pkg::DATA_WIDTH-1:0] data_in,
  // Read port pins
  input  wire logic                            read_clock,
  input  wire logic                            first_read_enable_n,
  input  wire logic                            second_read_enable_n,
  input  wire logic                            output_enable_n,
  input  wire logic                            reset_n,
  // Data outputs, three-state as data plus enable
  output logic      [sfpf_pkg::DATA_WIDTH-1:0] data_out,
  output logic                                 data_out_oe_n,
  // Flags
  output logic                                 empty_flag_n,
  output logic                                 full_flag_n,
  output logic                                 almost_empty_flag_n,
  output logic                                 almost_full_flag_n
);

  import sfpf_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [15:0] DEPTH_W = 16'(DEPTH);

  typedef struct packed {
    logic                  wclk_prev;
    logic                  rclk_prev;
    logic                  dual_mode;
    logic [AW:0]           wptr;
    logic [AW:0]           rptr;
    sfpf_sel_type          sel;
    logic [7:0]            empty_offset_low;
    logic [7:0]            empty_offset_high;
    logic [7:0]            full_offset_low;
    logic [7:0]            full_offset_high;
    logic [DATA_WIDTH-1:0] dout;
    logic                  oe_n;
    logic                  ef_n;
    logic                  ff_n;
    logic                  pae_n;
    logic                  paf_n;
  } sfpf_state_type;

  sfpf_state_type        cur;
  sfpf_state_type        next_state;
  logic [DATA_WIDTH-1:0] mem [DEPTH];

  // Every pin, device clocks included, passes two flops first.
  sfpf_sync_if #(.WIDTH(PIN_COUNT)) pins ();

  assign pins.raw = {write_clock, read_clock, reset_n,
                     first_write_enable_n, second_write_enable_or_load,
                     first_read_enable_n, second_read_enable_n,
                     output_enable_n, data_in};

  sfpf_sync #(.WIDTH(PIN_COUNT)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .port (pins)
  );

  logic                  wclk_s;
  logic                  rclk_s;
  logic                  rst_s_n;
  logic                  first_write_enable_n_s_n;
  logic                  second_write_enable_or_load_s;
  logic                  ren_s;
  logic                  oe_s_n;
  logic [DATA_WIDTH-1:0] din_s;
  logic                  wr_edge;
  logic                  rd_edge;
  logic                  off_wr;
  logic                  off_rd;
  logic                  fifo_wr;
  logic                  fifo_rd;
  logic [15:0]           n_value;
  logic [15:0]           m_value;
  logic [AW:0]           ptr_diff;

  assign wclk_s    = pins.synced[PIN_WCLK];
  assign rclk_s    = pins.synced[PIN_RCLK];
  assign rst_s_n   = pins.synced[PIN_RESET_N];
  assign first_write_enable_n_s_n  = pins.synced[PIN_FIRST_WRITE_ENABLE_N_N];
  assign second_write_enable_or_load_s = pins.synced[PIN_SECOND_WRITE_ENABLE_OR_LOAD];
  assign ren_s     = !pins.synced[PIN_FIRST_READ_ENABLE_N_N] && !pins.synced[PIN_SECOND_READ_ENABLE_N_N];
  assign oe_s_n    = pins.synced[PIN_OE_N];
  assign din_s     = pins.synced[PIN_DATA_LSB +: DATA_WIDTH];

  // Clock edges are seen even during device reset, so free-running
  // clocks need no special care.
  assign wr_edge = wclk_s && !cur.wclk_prev;
  assign rd_edge = rclk_s && !cur.rclk_prev;

  assign n_value = {cur.empty_offset_high, cur.empty_offset_low};
  assign m_value = {cur.full_offset_high, cur.full_offset_low};
  assign ptr_diff = cur.wptr - cur.rptr;

  // Load mode routes the second pin to the offset registers.
  assign off_wr = rst_s_n && wr_edge && !cur.dual_mode && !first_write_enable_n_s_n
                  && !second_write_enable_or_load_s;
  assign off_rd = rst_s_n && rd_edge && !cur.dual_mode && !second_write_enable_or_load_s
                  && ren_s;
  // Full blocks writes whatever the enables say.
  assign fifo_wr = rst_s_n && wr_edge && !first_write_enable_n_s_n && cur.ff_n
                   && second_write_enable_or_load_s;
  // Empty blocks reads; an offset read takes the cycle instead.
  assign fifo_rd = rst_s_n && rd_edge && ren_s && cur.ef_n
                   && (cur.dual_mode || second_write_enable_or_load_s);

  always_comb begin
    logic [AW:0] count;
    logic [15:0] count_w;
    logic [15:0] free_w;
    count      = '0;
    count_w    = '0;
    free_w     = '0;
    next_state = cur;
    next_state.wclk_prev = wclk_s;
    next_state.rclk_prev = rclk_s;
    next_state.oe_n      = oe_s_n;
    if (!rst_s_n) begin
      // Pin reset: empty, outputs low, mode taken from the pin.
      next_state.dual_mode         = second_write_enable_or_load_s;
      next_state.wptr              = '0;
      next_state.rptr              = '0;
      next_state.sel               = SEL_EMPTY_LOW;
      next_state.empty_offset_low  = EMPTY_OFFSET_LOW_RESET;
      next_state.empty_offset_high = EMPTY_OFFSET_HIGH_RESET;
      next_state.full_offset_low   = FULL_OFFSET_LOW_RESET;
      next_state.full_offset_high  = FULL_OFFSET_HIGH_RESET;
      next_state.dout              = '0;
      next_state.ef_n              = 1'b0;
      next_state.ff_n              = 1'b1;
      next_state.pae_n             = 1'b0;
      next_state.paf_n             = 1'b1;
    end else begin
      // One shared position; a simultaneous write and read both act and step it once.
      if (off_wr) begin
        case (cur.sel)
          SEL_EMPTY_LOW:  next_state.empty_offset_low  = din_s[7:0];
          SEL_EMPTY_HIGH: next_state.empty_offset_high = din_s[7:0];
          SEL_FULL_LOW:   next_state.full_offset_low   = din_s[7:0];
          SEL_FULL_HIGH:  next_state.full_offset_high  = din_s[7:0];
          default:        next_state.empty_offset_low  = din_s[7:0];
        endcase
      end
      if (off_rd) begin
        case (cur.sel)
          SEL_EMPTY_LOW:  next_state.dout = {1'b0, cur.empty_offset_low};
          SEL_EMPTY_HIGH: next_state.dout = {1'b0, cur.empty_offset_high};
          SEL_FULL_LOW:   next_state.dout = {1'b0, cur.full_offset_low};
          SEL_FULL_HIGH:  next_state.dout = {1'b0, cur.full_offset_high};
          default:        next_state.dout = '0;
        endcase
      end
      // Position wraps after four and is kept when load rises.
      if (off_wr || off_rd) begin
        next_state.sel = sfpf_sel_type'(2'(cur.sel + 2'h1));
      end
      if (fifo_wr) begin
        next_state.wptr = cur.wptr + 1'b1;
      end
      // Without a read the output register holds its word.
      if (fifo_rd) begin
        next_state.dout = mem[cur.rptr[AW-1:0]];
        next_state.rptr = cur.rptr + 1'b1;
      end
      // Pointers carry one extra bit so full and empty differ.
      count   = next_state.wptr - next_state.rptr;
      count_w = 16'(count);
      free_w  = DEPTH_W - count_w;
      // Both clocks are sampled on clk, so edge ordering is exact and
      // no extra deferral is ever needed.
      if (rd_edge) begin
        // Empty rises here; the first word follows on the next edge.
        next_state.ef_n  = (count_w != 16'h0000);
        next_state.pae_n = (count_w > n_value);
      end
      if (wr_edge) begin
        next_state.ff_n  = (count_w != DEPTH_W);
        next_state.paf_n = (free_w > m_value);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // The sampler flushes high, so the edge history starts high too;
      // otherwise the first clk after rstn would show a false edge.
      cur                   <= '0;
      cur.wclk_prev         <= 1'b1;
      cur.rclk_prev         <= 1'b1;
      cur.empty_offset_low  <= EMPTY_OFFSET_LOW_RESET;
      cur.empty_offset_high <= EMPTY_OFFSET_HIGH_RESET;
      cur.full_offset_low   <= FULL_OFFSET_LOW_RESET;
      cur.full_offset_high  <= FULL_OFFSET_HIGH_RESET;
      cur.dual_mode <= 1'b1;
      cur.oe_n      <= 1'b1;
      cur.ff_n      <= 1'b1;
      cur.paf_n     <= 1'b1;
    end else begin
      cur <= next_state;
    end
  end

  // Dual-ported storage, written at the write pointer only.
  always_ff @(posedge clk) begin
    if (fifo_wr) begin
      mem[cur.wptr[AW-1:0]] <= din_s;
    end
  end

  assign data_out            = cur.dout;
  assign data_out_oe_n       = cur.oe_n;
  assign empty_flag_n        = cur.ef_n;
  assign full_flag_n         = cur.ff_n;
  assign almost_empty_flag_n = cur.pae_n;
  assign almost_full_flag_n  = cur.paf_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_offset_write;
    off_wr;
  endsequence

  sequence s_blocked_read;
    rst_s_n && rd_edge && !cur.ef_n && !off_rd;
  endsequence

  a_full_blocks_write: assert property (
    (!cur.ff_n && rst_s_n) |=> $stable(cur.wptr))
    else $error("Write pointer moved while full.");

  a_empty_blocks_read: assert property (
    (!cur.ef_n && rst_s_n) |=> $stable(cur.rptr))
    else $error("Read pointer moved while empty.");

  a_empty_holds_data: assert property (
    s_blocked_read |=> $stable(cur.dout))
    else $error("Outputs changed on a read while empty.");

  a_empty_read_clock: assert property (
    (rst_s_n && !rd_edge) |=> ($stable(cur.ef_n) && $stable(cur.pae_n)))
    else $error("Read-side flag changed without a read clock edge.");

  a_full_write_clock: assert property (
    (rst_s_n && !wr_edge) |=> ($stable(cur.ff_n) && $stable(cur.paf_n)))
    else $error("Write-side flag changed without a write clock edge.");

  a_reset_outputs: assert property (
    !rst_s_n |=> (cur.dout == '0 && !cur.ef_n && cur.ff_n
                  && cur.dual_mode == $past(second_write_enable_or_load_s)))
    else $error("Pin reset did not give the empty state.");

  a_offset_order: assert property (
    s_offset_write |=> cur.sel == sfpf_sel_type'(2'($past(cur.sel) + 2'h1)))
    else $error("Offset position did not advance by one.");

  a_almost_empty: assert property (
    (rst_s_n && rd_edge && !off_wr) |=>
      (cur.pae_n == (16'(ptr_diff) > n_value)))
    else $error("Almost-empty flag disagrees with the word count.");

  a_first_word: assert property (
    (rst_s_n && rd_edge && !cur.ef_n) |=> $stable(cur.rptr))
    else $error("A word was read on the edge that raised empty.");

  sequence s_write_side;
    rst_s_n && wr_edge && !off_wr;
  endsequence

  a_full_flag_count: assert property (
    s_write_side |=> (cur.ff_n == (16'(ptr_diff) != DEPTH_W)))
    else $error("Full flag disagrees with the word count.");

  a_almost_full: assert property (
    s_write_side |=> (cur.paf_n == ((DEPTH_W - 16'(ptr_diff)) > m_value)))
    else $error("Almost-full flag disagrees with the free space.");

  a_load_blocks_write: assert property (
    (rst_s_n && !second_write_enable_or_load_s) |=> $stable(cur.wptr))
    else $error("A word was stored while the second pin was low.");

  a_offset_read: assert property (
    (off_rd && cur.sel == SEL_EMPTY_LOW) |=>
      (cur.dout == {1'b0, $past(cur.empty_offset_low)}))
    else $error("Offset read did not show the empty low offset.");

  a_output_release: assert property (
    1'b1 |=> (cur.oe_n == $past(oe_s_n)))
    else $error("Output enable did not follow its pin.");

endmodule // sfpf_fifo

// ### test/sfpf_partner.sv
// Purpose: Writer and reader logic that clocks words and offsets through.
// Assumes: Pins change on falling clk; device clocks idle between transfers.
// Notes:   Device clocks stay high for three clk periods and low for at least five, so they run at an eighth of the clk rate or slower.
`timescale 1ns/1ps
module sfpf_partner (
  // System clock
  input  wire logic                            clk,
  // Write side pins
  output logic                                 write_clock,
  output logic                                 first_write_enable_n,
  output logic                                 second_write_enable_or_load,
  output logic      [sfpf_pkg::DATA_WIDTH-1:0] data_in,
  // Read side pins
  output logic                                 read_clock,
  output logic                                 first_read_enable_n,
  output logic                                 second_read_enable_n,
  output logic                                 reset_n
);
  import sfpf_pkg::*;

  initial begin
    write_clock = 1'b0;
    read_clock = 1'b0;
    first_write_enable_n = 1'b1;
    second_write_enable_or_load = 1'b1;
    data_in = 9'h000;
    first_read_enable_n = 1'b1;
    second_read_enable_n = 1'b1;
    reset_n = 1'b1;
  end

  // One device clock pulse, raised one clk after the enables settle.
  task automatic pulse(input logic wr);
    @(negedge clk);
    if (wr) write_clock = 1'b1;
    else read_clock = 1'b1;
    repeat (3) @(negedge clk);
    write_clock = 1'b0;
    read_clock = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // Offset and FIFO accesses never overlap, so one task runs at a time.
  task automatic put(input logic [8:0] d, input logic en2);
    @(negedge clk);
    first_write_enable_n = 1'b0;
    second_write_enable_or_load = en2;
    data_in = d;
    pulse(1'b1);
    first_write_enable_n = 1'b1;
    second_write_enable_or_load = 1'b1;
    data_in = ~d;
  endtask

  task automatic take(input logic ld);
    @(negedge clk);
    first_read_enable_n = 1'b0;
    second_read_enable_n = 1'b0;
    second_write_enable_or_load = ld;
    pulse(1'b0);
    first_read_enable_n = 1'b1;
    second_read_enable_n = 1'b1;
    second_write_enable_or_load = 1'b1;
  endtask

  // Each device clock pulses once, with the first enables idle and the second pin at the mode, while reset is low.
  task automatic pin_reset(input logic mode);
    @(negedge clk);
    reset_n = 1'b0;
    second_write_enable_or_load = mode;
    pulse(1'b1);
    pulse(1'b0);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    second_write_enable_or_load = 1'b1;
  endtask
endmodule // sfpf_partner

// ### test/sfpf_fifo_tb.sv
// Purpose: Self-checking bench for the programmable-flag FIFO.
// Assumes: Partner tasks end only after the device has answered.
// Notes:   Expected data and flags come from a queue model of the contents.
`timescale 1ns/1ps
module sfpf_fifo_tb;
  import sfpf_pkg::*;
  localparam int DEPTH = 64;

  logic       clk;
  logic       rstn;
  logic       write_clock;
  logic       first_write_enable_n;
  logic       second_write_enable_or_load;
  logic [8:0] data_in;
  logic       read_clock;
  logic       first_read_enable_n;
  logic       second_read_enable_n;
  logic       output_enable_n;
  logic       reset_n;
  logic [8:0] data_out;
  logic       data_out_oe_n;
  logic       empty_flag_n;
  logic       full_flag_n;
  logic       almost_empty_flag_n;
  logic       almost_full_flag_n;
  int         miscompares;
  int         check_count;
  int         nval;
  int         mval;
  logic [8:0] last;
  logic       ef_m, ff_m, pae_m, paf_m;
  logic [8:0] q[$];
  logic [8:0] offs[4] = '{9'h003, 9'h000, 9'h004, 9'h000};
  wire  [3:0] flag_bits = {empty_flag_n, full_flag_n,
                           almost_empty_flag_n, almost_full_flag_n};

  sfpf_fifo #(.DEPTH(DEPTH)) i_dut (.clk(clk), .rstn(rstn),
    .write_clock(write_clock), .first_write_enable_n(first_write_enable_n),
    .second_write_enable_or_load(second_write_enable_or_load),
    .data_in(data_in), .read_clock(read_clock),
    .first_read_enable_n(first_read_enable_n),
    .second_read_enable_n(second_read_enable_n),
    .output_enable_n(output_enable_n), .reset_n(reset_n),
    .data_out(data_out), .data_out_oe_n(data_out_oe_n),
    .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n));

  sfpf_partner i_partner (.clk(clk), .write_clock(write_clock),
    .first_write_enable_n(first_write_enable_n),
    .second_write_enable_or_load(second_write_enable_or_load),
    .data_in(data_in), .read_clock(read_clock),
    .first_read_enable_n(first_read_enable_n),
    .second_read_enable_n(second_read_enable_n), .reset_n(reset_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [8:0] exp,
                       input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Flags as empty, full, almost empty, almost full. Each side moves only
  // its own flags on its own clock edge, so the model keeps them as state.
  function automatic logic [3:0] fexp();
    return {ef_m, ff_m, pae_m, paf_m};
  endfunction

  // Any read clock edge re-evaluates the read-side flags.
  task automatic rside;
    ef_m  = (q.size() != 0);
    pae_m = (q.size() > nval);
  endtask

  // A pin reset empties the FIFO and restores the default offsets.
  task automatic dev_reset(input logic mode);
    i_partner.pin_reset(mode);
    q.delete();
    {ef_m, ff_m, pae_m, paf_m} = 4'h5;
    nval = 7;
    mval = 7;
    last = 9'h000;
  endtask

  task automatic wr(input logic [8:0] d);
    i_partner.put(d, 1'b1);
    if (ff_m) q.push_back(d);
    ff_m  = (q.size() != DEPTH);
    paf_m = (DEPTH - q.size() > mval);
    check("flags", {5'h00, fexp()}, {5'h00, flag_bits});
  endtask

  // After writes into an empty FIFO the first read edge only raises empty.
  task automatic rd;
    i_partner.take(1'b1);
    if (ef_m) last = q.pop_front();
    rside();
    check("data_out", last, data_out);
    check("flags", {5'h00, fexp()}, {5'h00, flag_bits});
  endtask

  // Fills past full so writes are refused, then drains past empty.
  task automatic cycle(input int base);
    for (int i = 0; i <= DEPTH; i++) wr(9'(base + i * 5));
    for (int i = 0; i <= DEPTH + 1; i++) rd();
  endtask

  task automatic wrap_up;
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end

  initial begin
    rstn = 1'b0;
    output_enable_n = 1'b0;
    miscompares = 0;
    check_count = 0;
    nval = 7;
    mval = 7;
    last = 9'h000;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    dev_reset(1'b1);
    check("flags", 9'h005, {5'h00, flag_bits});
    check("data_out", 9'h000, data_out);
    check("oe", 9'h000, {8'h00, data_out_oe_n});
    rd();
    i_partner.put(9'h155, 1'b0);
    check("flags", 9'h005, {5'h00, flag_bits});
    cycle(3);
    output_enable_n = 1'b1;
    repeat (4) @(negedge clk);
    check("oe", 9'h001, {8'h00, data_out_oe_n});
    output_enable_n = 1'b0;
    repeat (4) @(negedge clk);
    check("oe", 9'h000, {8'h00, data_out_oe_n});
    dev_reset(1'b0);
    check("flags", 9'h005, {5'h00, flag_bits});
    i_partner.put(offs[0], 1'b0);
    i_partner.put(offs[1], 1'b0);
    wr(9'h0AA);
    i_partner.put(offs[2], 1'b0);
    i_partner.put(offs[3], 1'b0);
    nval = 3;
    mval = 4;
    for (int k = 0; k < 4; k++) begin
      i_partner.take(1'b0);
      check("offset", offs[k], data_out);
      // An offset read is still a read clock edge for the flags.
      rside();
    end
    last = offs[3];
    cycle(9'h101);
    wrap_up();
  end
endmodule // sfpf_fifo_tb
